// *** src/operand_address_generator.sv ***
// operand address generator: short, long and indirect data addressing
`timescale 1ns/1ps

// Notes on behaviour
// - word register at base pointer plus twice field; byte register plus field.
// - short direct 00h..EFh addresses control word at FE00h plus twice value.
// - short direct byte operations reach only the control word's low byte.
// - short direct F0h..FFh uses low four bits as a bank register.
// - bit word offset 00h..7Fh addresses RAM at FD00h plus twice offset.
// - bit word offset 80h..EFh addresses control words at FF00h plus twice the offset's low seven bits.
// - bit word offset F0h..FFh addresses a bank word register via low bits.
// - single bit operand is eight-bit word offset plus four-bit bit index.
// - long address bits 13:0 are page offset, bits 15:14 pick a page pointer.
// - physical address is page pointer low four bits above the 14-bit offset.
// - segmentation off keeps segment 0, only two pointer bits count.
// - word access to odd long or indirect address traps instead of completing.
// - after reset page pointers map long addresses onto identical physical ones.
// - pointer location is base pointer plus twice field; contents form address.
// - restricted instructions select the pointer with a two-bit field.
// - indirect long addresses are translated through the page pointers.
// - pre-decrement lowers the pointer by one or two before addressing.
// - constant-offset mode adds a 16-bit constant to the pointer.
// - post-increment raises the pointer by one or two after addressing.
module operand_address_generator
	import operand_address_pkg::*;
#(
	parameter int unsigned PTR_W = 10
) (
	// clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_n_i,
	// operand request from the decoder
	input  wire logic                   req_valid_i,
	input  wire operand_mode_type       req_mode_i,
	input  wire logic                   req_byte_i,
	input  wire logic [11:0]            req_field_i,
	input  wire logic [LONG_W-1:0]      req_long_i,
	input  wire logic [LONG_W-1:0]      req_pointer_i,
	input  wire logic [LONG_W-1:0]      bank_base_pointer_i,
	input  wire logic                   seg_disable_i,
	// page pointer update
	input  wire logic                   page_wr_i,
	input  wire logic [1:0]             page_wr_sel_i,
	input  wire logic [PTR_W-1:0]       page_wr_data_i,
	// result to the memory access path
	output logic                        addr_valid_o,
	output logic [PHYS_W-1:0]           addr_o,
	output logic                        addr_byte_o,
	output logic [3:0]                  bit_index_o,
	output logic                        trap_o,
	// pointer write back
	output logic                        wb_valid_o,
	output logic [LONG_W-1:0]           wb_addr_o,
	output logic [LONG_W-1:0]           wb_data_o
);

	// =====================================================================
	// parameter check
	if (PTR_W < SEG_BITS) begin : g_width_check
		$error("page pointer narrower than four bits");
	end

	// =====================================================================
	// page pointers
	logic [PTR_W-1:0] data_page_pointer [PAGE_CNT];

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < PAGE_CNT; i++) begin
				data_page_pointer[i] <= PTR_W'(i);
			end
		end else if (page_wr_i) begin
			data_page_pointer[page_wr_sel_i] <= page_wr_data_i;
		end
	end

	// =====================================================================
	// address forming
	logic [LONG_W-1:0] bank_word_addr;
	logic [LONG_W-1:0] ptr_loc;
	logic [LONG_W-1:0] step;
	logic [LONG_W-1:0] long_addr;
	logic [LONG_W-1:0] short_addr;
	logic [LONG_W-1:0] next_pointer;
	logic [PTR_W-1:0]  page_sel;
	logic [PHYS_W-1:0] phys_long;
	logic              is_long;
	logic              modifies;
	logic              odd_trap;
	logic [7:0]        field8;

	assign field8 = req_field_i[7:0];
	assign step   = req_byte_i ? BYTE_STEP : WORD_STEP;
	// bank word register from the low four bits
	assign bank_word_addr = bank_base_pointer_i + {11'h000, req_field_i[3:0], 1'b0};

	always_comb begin
		short_addr = '0;
		unique case (req_mode_i)
			MODE_WORD_REG: begin
				short_addr = bank_word_addr;
			end
			MODE_BYTE_REG: begin
				short_addr = bank_base_pointer_i + {12'h000, req_field_i[3:0]};
			end
			MODE_SHORT_DIRECT: begin
				if (field8 >= BANK_SHORT_FIRST) begin
					short_addr = req_byte_i ?
						bank_base_pointer_i + {12'h000, req_field_i[3:0]} : bank_word_addr;
				end else begin
					// even address: a byte access lands on the low byte only
					short_addr = CONTROL_WORD_BASE + {7'h00, field8, 1'b0};
				end
			end
			MODE_BIT_WORD, MODE_BIT_SINGLE: begin
				if (field8 <= RAM_BIT_LAST) begin
					short_addr = RAM_BIT_BASE + {7'h00, field8, 1'b0};
				end else if (field8 < BANK_SHORT_FIRST) begin
					short_addr = CONTROL_BIT_BASE + {8'h00, field8[6:0], 1'b0};
				end else begin
					short_addr = bank_word_addr;
				end
			end
			default: begin
				short_addr = '0;
			end
		endcase
	end

	// pointer location: two-bit field restricts to the first four registers
	always_comb begin
		if (req_mode_i == MODE_IND_LOW4) begin
			ptr_loc = bank_base_pointer_i + {13'h0000, req_field_i[1:0], 1'b0};
		end else begin
			ptr_loc = bank_word_addr;
		end
	end

	always_comb begin
		long_addr    = req_pointer_i;
		next_pointer = req_pointer_i;
		unique case (req_mode_i)
			MODE_LONG: begin
				long_addr = req_long_i;
			end
			MODE_IND_PREDEC: begin
				next_pointer = req_pointer_i - step;
				long_addr    = next_pointer;
			end
			MODE_IND_POSTINC: begin
				next_pointer = req_pointer_i + step;
			end
			MODE_IND_OFFSET: begin
				long_addr = req_pointer_i + req_long_i;
			end
			default: begin
				long_addr = req_pointer_i;
			end
		endcase
	end

	assign is_long  = req_mode_i inside {MODE_LONG, MODE_IND, MODE_IND_LOW4, MODE_IND_PREDEC,
		MODE_IND_POSTINC, MODE_IND_OFFSET};
	assign modifies = req_mode_i inside {MODE_IND_PREDEC, MODE_IND_POSTINC};
	assign odd_trap = is_long && !req_byte_i && long_addr[0];

	// page translation shared by long and indirect modes
	assign page_sel = data_page_pointer[long_addr[LONG_W-1:OFFSET_W]];
	always_comb begin
		if (seg_disable_i) begin
			phys_long = {2'b00, page_sel[NOSEG_BITS-1:0], long_addr[OFFSET_W-1:0]};
		end else begin
			phys_long = {page_sel[SEG_BITS-1:0], long_addr[OFFSET_W-1:0]};
		end
	end

	// =====================================================================
	// result registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_valid_o <= 1'b0;
			trap_o       <= 1'b0;
		end else begin
			addr_valid_o <= req_valid_i && !odd_trap;
			trap_o       <= req_valid_i && odd_trap;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_o      <= '0;
			addr_byte_o <= 1'b0;
			bit_index_o <= '0;
		end else if (req_valid_i) begin
			addr_o      <= is_long ? phys_long : {2'b00, short_addr};
			addr_byte_o <= req_byte_i;
			bit_index_o <= (req_mode_i == MODE_BIT_SINGLE) ? req_field_i[11:8] : 4'h0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wb_valid_o <= 1'b0;
			wb_addr_o  <= '0;
			wb_data_o  <= '0;
		end else begin
			wb_valid_o <= req_valid_i && modifies && !odd_trap;
			if (req_valid_i) begin
				wb_addr_o <= ptr_loc;
				wb_data_o <= next_pointer;
			end
		end
	end

	// =====================================================================
	// checks
	sequence s_word_req;
		req_valid_i && !req_byte_i;
	endsequence

	sequence s_odd_long;
		s_word_req and is_long && long_addr[0];
	endsequence

	a_odd_trap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_odd_long |=> trap_o && !addr_valid_o && !wb_valid_o)
		else $error("odd word access did not trap");

	a_word_reg: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_WORD_REG |=>
		addr_o == {2'b00, $past(bank_base_pointer_i) + {11'h000, $past(req_field_i[3:0]), 1'b0}})
		else $error("word register address wrong");

	a_short_ctrl: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_SHORT_DIRECT && field8 < BANK_SHORT_FIRST |=>
		addr_o[15:9] == CONTROL_WORD_BASE[15:9] && addr_o[0] == 1'b0)
		else $error("short direct control word address wrong");

	a_bit_ram: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_BIT_WORD && field8 <= RAM_BIT_LAST |=>
		addr_o[15:8] == RAM_BIT_BASE[15:8] && addr_o[7:1] == $past(req_field_i[6:0]))
		else $error("bit word RAM address wrong");

	a_bit_ctrl: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_BIT_WORD && field8 > RAM_BIT_LAST &&
		field8 < BANK_SHORT_FIRST |=> addr_o[15:8] == CONTROL_BIT_BASE[15:8])
		else $error("bit word control address wrong");

	a_bit_index: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_BIT_SINGLE |=> bit_index_o == $past(req_field_i[11:8]))
		else $error("bit index wrong");

	a_reset_map: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> data_page_pointer[3] == PTR_W'(3))
		else $error("page pointer reset value wrong");

	a_noseg: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && is_long && seg_disable_i && !odd_trap |=> addr_o[17:16] == 2'b00)
		else $error("segment 0 not kept");

	a_page_offset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_LONG |=> addr_o[13:0] == $past(req_long_i[13:0]))
		else $error("page offset not kept");

	a_predec_wb: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_IND_PREDEC && req_byte_i |=>
		wb_valid_o && wb_data_o == $past(req_pointer_i) - BYTE_STEP)
		else $error("pre-decrement write back wrong");

	a_postinc_wb: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_IND_POSTINC && !odd_trap |=>
		wb_valid_o && wb_data_o == $past(req_pointer_i) + $past(step) ##1
		!wb_valid_o || $past(req_valid_i))
		else $error("post-increment write back wrong");

	a_short_bank: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_SHORT_DIRECT && !req_byte_i &&
		field8 >= BANK_SHORT_FIRST |=>
		addr_o == {2'b00, $past(bank_base_pointer_i) + {11'h000, $past(req_field_i[3:0]), 1'b0}})
		else $error("short direct bank register address wrong");

	a_bit_bank: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_BIT_WORD && field8 >= BANK_SHORT_FIRST |=>
		addr_o[15:0] == $past(bank_base_pointer_i) + {11'h000, $past(req_field_i[3:0]), 1'b0})
		else $error("bit word bank register address wrong");

	a_ptr_low4: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_IND_LOW4 |=>
		wb_addr_o == $past(bank_base_pointer_i) + {13'h0000, $past(req_field_i[1:0]), 1'b0})
		else $error("two-bit pointer location wrong");

	a_ptr_loc: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_IND_POSTINC |=>
		wb_addr_o == $past(bank_base_pointer_i) + {11'h000, $past(req_field_i[3:0]), 1'b0})
		else $error("pointer location wrong");

	a_offset_add: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_IND_OFFSET |=>
		addr_o[13:0] == 14'($past(req_pointer_i) + $past(req_long_i)))
		else $error("constant offset not added");

	a_seg_page: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		req_valid_i && req_mode_i == MODE_LONG && !seg_disable_i |=>
		addr_o[17:14] == 4'($past(data_page_pointer[req_long_i[15:14]])))
		else $error("page pointer not placed above offset");

endmodule

// *** src/operand_address_pkg.sv ***
// constants and types shared by the operand address generator
package operand_address_pkg;

	// =====================================================================
	// widths
	localparam int unsigned LONG_W     = 16;
	localparam int unsigned PHYS_W     = 18;
	localparam int unsigned OFFSET_W   = 14;
	localparam int unsigned PAGE_CNT   = 4;
	localparam int unsigned SEG_BITS   = 4;
	localparam int unsigned NOSEG_BITS = 2;

	// =====================================================================
	// short mode bases and ranges
	localparam logic [15:0] CONTROL_WORD_BASE = 16'hFE00;
	localparam logic [15:0] RAM_BIT_BASE      = 16'hFD00;
	localparam logic [15:0] CONTROL_BIT_BASE  = 16'hFF00;
	localparam logic [7:0]  BANK_SHORT_FIRST  = 8'hF0;
	localparam logic [7:0]  RAM_BIT_LAST      = 8'h7F;
	localparam logic [15:0] BYTE_STEP         = 16'h0001;
	localparam logic [15:0] WORD_STEP         = 16'h0002;

	// =====================================================================
	// operand modes offered by the decoder
	typedef enum logic [3:0] {
		MODE_WORD_REG,
		MODE_BYTE_REG,
		MODE_SHORT_DIRECT,
		MODE_BIT_WORD,
		MODE_BIT_SINGLE,
		MODE_LONG,
		MODE_IND,
		MODE_IND_LOW4,
		MODE_IND_PREDEC,
		MODE_IND_POSTINC,
		MODE_IND_OFFSET
	} operand_mode_type;

endpackage

// *** bench/bank_file_model.sv ***
// bank word register file that feeds and absorbs indirect pointers
`timescale 1ns/1ps
module bank_file_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_n_i,
	// pointer read
	input  wire logic [3:0]  sel_i,
	input  wire logic [15:0] base_i,
	output logic      [15:0] ptr_o,
	// pointer write back
	input  wire logic        wb_valid_i,
	input  wire logic [15:0] wb_addr_i,
	input  wire logic [15:0] wb_data_i
);
	logic [15:0] regs [16];
	logic [15:0] slot;
	assign ptr_o = regs[sel_i];
	// register slot recovered from its location above the bank base
	assign slot = (wb_addr_i - base_i) >> 1;
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= 16'h4000 + 16'(i * 6);
			end
		end else if (wb_valid_i) begin
			regs[slot[3:0]] <= wb_data_i;
		end
	end
endmodule

// *** bench/operand_address_generator_tb.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module operand_address_generator_tb;
	import operand_address_pkg::*;
	typedef struct packed {
		logic        byt;
		logic        trap;
		logic [17:0] addr;
		logic [3:0]  bit_idx;
		logic        wb;
		logic [15:0] wb_addr;
		logic [15:0] wb_data;
	} note_type;
	logic             ref_clk_i = 1'b0;
	logic             reset_n_i = 1'b0;
	logic             req_valid_i = 1'b0;
	operand_mode_type req_mode_i = MODE_WORD_REG;
	logic             req_byte_i = 1'b0;
	logic [11:0]      req_field_i = 12'h000;
	logic [15:0]      req_long_i = 16'h0000;
	logic [15:0]      req_pointer_i;
	logic [15:0]      base = 16'hFC00;
	logic             seg_disable_i = 1'b0;
	logic             page_wr_i = 1'b0;
	logic [1:0]       page_wr_sel_i = 2'h0;
	logic [9:0]       page_wr_data_i = 10'h000;
	logic             addr_valid_o, addr_byte_o, trap_o, wb_valid_o;
	logic [17:0]      addr_o;
	logic [3:0]       bit_index_o;
	logic [15:0]      wb_addr_o, wb_data_o;
	logic [3:0]       sel = 4'h0;
	logic [9:0]       page [4];
	logic [15:0]      rnd = 16'h6516;
	logic [15:0]      v;
	logic [7:0]       o;
	logic [7:0]       edges [6] = '{8'h00, 8'h7F, 8'h80, 8'hEF, 8'hF0, 8'hFF};
	note_type         notes [$];
	note_type         seen;
	int               err_total = 0;
	int               cmp_count = 0;

	always #50 ref_clk_i = ~ref_clk_i;

	operand_address_generator #(.PTR_W(10)) dut (.ref_clk_i, .reset_n_i, .req_valid_i,
		.req_mode_i, .req_byte_i, .req_field_i, .req_long_i, .req_pointer_i,
		.bank_base_pointer_i(base), .seg_disable_i, .page_wr_i, .page_wr_sel_i,
		.page_wr_data_i, .addr_valid_o, .addr_o, .addr_byte_o, .bit_index_o, .trap_o,
		.wb_valid_o, .wb_addr_o, .wb_data_o);
	bank_file_model partner (.ref_clk_i, .reset_n_i, .sel_i(sel), .base_i(base),
		.ptr_o(req_pointer_i), .wb_valid_i(wb_valid_o), .wb_addr_i(wb_addr_o),
		.wb_data_i(wb_data_o));

	// =====================================================================
	// expectations
	function automatic logic [15:0] next_rnd();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction
	function automatic note_type na(input logic [15:0] a, input logic [3:0] k);
		return '{1'b0, 1'b0, {2'h0, a}, k, 1'b0, 16'h0000, 16'h0000};
	endfunction
	function automatic note_type ln(input logic [15:0] la, input logic b);
		logic [9:0] p;
		p = page[la[15:14]];
		if (!b && la[0]) return '{1'b0, 1'b1, 18'h0, 4'h0, 1'b0, 16'h0, 16'h0};
		if (seg_disable_i) return na(16'h0, 4'h0) | {1'b0, 2'h0, p[1:0], la[13:0], 37'h0};
		return na(16'h0, 4'h0) | {1'b0, p[3:0], la[13:0], 37'h0};
	endfunction
	function automatic logic [15:0] bit_exp(input logic [7:0] a);
		if (a <= 8'h7F) return 16'hFD00 + {7'h0, a, 1'b0};
		if (a < 8'hF0) return 16'hFE00 + {7'h0, a, 1'b0};
		return base + {11'h0, a[3:0], 1'b0};
	endfunction
	function automatic logic [15:0] short_exp(input logic [7:0] a, input logic b);
		if (a < 8'hF0) return 16'hFE00 + {7'h0, a, 1'b0};
		return base + (b ? {12'h0, a[3:0]} : {11'h0, a[3:0], 1'b0});
	endfunction

	// =====================================================================
	// drivers
	task automatic issue(input operand_mode_type m, input logic b, input logic [11:0] f,
			input logic [15:0] la, input note_type n);
		@(posedge ref_clk_i);
		#5;
		req_valid_i = 1'b1;
		req_mode_i = m;
		req_byte_i = b;
		req_field_i = f;
		req_long_i = la;
		n.byt = b;
		notes.push_back(n);
	endtask
	task automatic idle(input int k);
		repeat (k) begin
			@(posedge ref_clk_i);
			#5;
			req_valid_i = 1'b0;
		end
	endtask
	task automatic page_set(input logic [1:0] q, input logic [9:0] val);
		@(posedge ref_clk_i);
		#5;
		req_valid_i = 1'b0;
		page_wr_i = 1'b1;
		page_wr_sel_i = q;
		page_wr_data_i = val;
		page[q] = val;
		idle(1);
		page_wr_i = 1'b0;
	endtask
	task automatic indirect(input operand_mode_type m, input logic b, input logic [3:0] r,
			input logic [15:0] k);
		logic [15:0] p;
		logic [15:0] d;
		logic [15:0] la;
		note_type    n;
		sel = (m == MODE_IND_LOW4) ? {2'h0, r[1:0]} : r;
		#1;
		p = req_pointer_i;
		d = b ? 16'h0001 : 16'h0002;
		la = (m == MODE_IND_PREDEC) ? p - d : p;
		if (m == MODE_IND_OFFSET) la = p + k;
		n = ln(la, b);
		n.wb = !n.trap && (m == MODE_IND_PREDEC || m == MODE_IND_POSTINC);
		n.wb_addr = base + {11'h0, sel, 1'b0};
		n.wb_data = (m == MODE_IND_POSTINC) ? p + d : la;
		issue(m, b, {8'h00, r}, k, n);
	endtask

	// =====================================================================
	// comparison and verdict
	task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
		cmp_count++;
		if (exp !== got) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	task automatic conclude();
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		#1;
		if (addr_valid_o === 1'b1 || trap_o === 1'b1) begin
			if (notes.size() == 0) begin
				check("spare result", 18'h0, 18'h1);
			end else begin
				seen = notes.pop_front();
				check("trap", {17'h0, seen.trap}, {17'h0, trap_o});
				check("valid", {17'h0, !seen.trap}, {17'h0, addr_valid_o});
				if (!seen.trap) check("addr", seen.addr, addr_o);
				if (!seen.trap) check("byte", {17'h0, seen.byt}, {17'h0, addr_byte_o});
				if (!seen.trap) check("bit", {14'h0, seen.bit_idx}, {14'h0, bit_index_o});
				check("wb valid", {17'h0, seen.wb}, {17'h0, wb_valid_o});
				if (seen.wb) check("wb addr", {2'h0, seen.wb_addr}, {2'h0, wb_addr_o});
				if (seen.wb) check("wb data", {2'h0, seen.wb_data}, {2'h0, wb_data_o});
			end
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		conclude();
	end

	initial begin
		page = '{10'h000, 10'h001, 10'h002, 10'h003};
		repeat (4) @(posedge ref_clk_i);
		#5;
		reset_n_i = 1'b1;
		// stage 0 identity map, 1 loaded pointers, 2 segmentation off
		for (int s = 0; s < 3; s++) begin
			for (int q = 0; q < 4 && s > 0; q++) begin
				v = next_rnd();
				page_set(q[1:0], v[9:0]);
			end
			seg_disable_i = (s == 2);
			for (int i = 0; i < 8; i++) begin
				base = next_rnd() & 16'hFFFE;
				v = next_rnd();
				o = (i < 6) ? edges[i] : v[7:0];
				issue(MODE_WORD_REG, 1'b0, v[11:0], v, na(base + {11'h0, v[3:0], 1'b0}, 4'h0));
				issue(MODE_BYTE_REG, 1'b1, v[11:0], v, na(base + {12'h0, v[3:0]}, 4'h0));
				issue(MODE_SHORT_DIRECT, v[4], {4'h0, o}, v, na(short_exp(o, v[4]), 4'h0));
				issue(MODE_BIT_WORD, v[5], {4'h0, o}, v, na(bit_exp(o), 4'h0));
				issue(MODE_BIT_SINGLE, v[6], {v[15:12], o}, v, na(bit_exp(o), v[15:12]));
				issue(MODE_LONG, v[7], 12'h000, v, ln(v, v[7]));
				for (int m = MODE_IND; m <= MODE_IND_OFFSET; m++) begin
					indirect(operand_mode_type'(m), v[m], v[15:12], next_rnd());
					idle(2);
				end
			end
		end
		// mid-run reset must bring back the identity page map
		idle(2);
		reset_n_i = 1'b0;
		page = '{10'h000, 10'h001, 10'h002, 10'h003};
		idle(2);
		reset_n_i = 1'b1;
		v = next_rnd();
		issue(MODE_LONG, 1'b1, 12'h000, v, ln(v, 1'b1));
		idle(3);
		check("pending", 18'h0, 18'(notes.size()));
		conclude();
	end
endmodule
